// >>> src/iaf_regs.sv
// Info and converter front-end register bank with APB slave and modulator bit capture
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - Decode 128 word addresses, 32-bit registers
// - Word holds one 32-bit or two 16-bit values
// - Info selector picks type/version/date/time/variant/build
// - Time word nibble digits, 24-bit maximum
// - Raw selector 0: current1 high, current0 low
// - Selector 1: supply low, input A high
// - Source 2 clock driven out, 3 comparator
// - Invert bit inverts incoming bitstream
// - Sample-clock bit: divided or full clock
// - Modulator clock from 32-bit phase increment
module iaf_regs
  import iaf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire iaf_raw_s raw_i,
  input wire logic [1:0] modulator_bitstream_i,
  input wire logic [1:0] mclk_ext_i,
  output logic [1:0] mclk_o,
  output logic [1:0] mclk_oe_o,
  output logic [1:0] bit_o,
  output logic [1:0] bit_valid_o
);
  iaf_state_s s_reg;
  iaf_state_s s_next;
  logic [IAF_ADDR_W-1:0] idx;
  logic wr_en;
  logic rd_en;
  iaf_chcfg_s cfg_a;
  iaf_chcfg_s cfg_b;

  // Two 16-bit halves packed into one word
  function automatic logic [31:0] iaf_pair(input logic [15:0] lo, input logic [15:0] hi);
    iaf_pair = ((32'(hi) << IAF_CH_B_POS) & IAF_HI_MASK) | (32'(lo) & IAF_LO_MASK);
  endfunction

  function automatic logic [31:0] iaf_info(input logic [31:0] sel);
    logic [7:0] a;
    a = 8'(sel & IAF_SEL_MASK);
    unique case (a)
      8'h00: iaf_info = IAF_HW_TYPE;
      8'h01: iaf_info = IAF_HW_VERSION;
      8'h02: iaf_info = IAF_HW_DATE;
      8'h03: iaf_info = IAF_HW_TIME & 32'h00FF_FFFF;
      8'h04: iaf_info = IAF_HW_VARIANT;
      8'h05: iaf_info = IAF_HW_BUILD;
      default: iaf_info = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [31:0] iaf_raw(input logic [31:0] sel, input iaf_raw_s r);
    logic [1:0] a;
    a = 2'(sel & IAF_SEL_MASK);
    unique case (a)
      2'h0: iaf_raw = iaf_pair(r.phase_current0_sample, r.phase_current1_sample);
      2'h1: iaf_raw = iaf_pair(r.supply_voltage_sample, r.analog_input_a_sample);
      2'h2: iaf_raw = iaf_pair(r.analog_input_b_sample, r.angle_sensor_ux_sample);
      2'h3: iaf_raw = iaf_pair(r.angle_sensor_vn_sample, r.angle_sensor_wy_sample);
    endcase
  endfunction

  function automatic logic [31:0] iaf_strb(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    iaf_strb = r;
  endfunction

  // Word index from byte address, 128 words
  assign idx = paddr_i[IAF_ADDR_W+1:2];
  assign wr_en = psel_i && penable_i && pwrite_i && s_reg.pready_reg;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign cfg_a = iaf_chcfg_s'(s_reg.modulator_config_reg[15:0]);
  assign cfg_b = iaf_chcfg_s'(s_reg.modulator_config_reg[31:16]);

  always_comb begin
    logic [32:0] sum_a;
    logic [32:0] sum_b;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] ext_edge;
    logic [1:0] tick;
    iaf_chcfg_s ch;
    sum_a = 33'h0_0000_0000;
    sum_b = 33'h0_0000_0000;
    rise = 2'b00;
    fall = 2'b00;
    ext_edge = 2'b00;
    tick = 2'b00;
    ch = cfg_a;
    s_next = s_reg;
    s_next.modulator_bitstream_s1_reg = modulator_bitstream_i;
    s_next.modulator_bitstream_s2_reg = s_reg.modulator_bitstream_s1_reg;
    s_next.mclkin_s1_reg = mclk_ext_i;
    s_next.mclkin_s2_reg = s_reg.mclkin_s1_reg;
    s_next.mclkin_prev_reg = s_reg.mclkin_s2_reg;
    // Phase accumulators, MSB is the modulator clock
    sum_a = {1'b0, s_reg.acc_a_reg} + {1'b0, s_reg.modulator_clock_increment_a_reg} + 33'h0_0000_0001;
    sum_b = {1'b0, s_reg.acc_b_reg} + {1'b0, s_reg.modulator_clock_increment_b_reg} + 33'h0_0000_0001;
    s_next.acc_a_reg = sum_a[31:0];
    s_next.acc_b_reg = sum_b[31:0];
    s_next.mclk_reg = {s_next.acc_b_reg[31], s_next.acc_a_reg[31]};
    rise = s_next.mclk_reg & ~s_reg.mclk_reg;
    fall = ~s_next.mclk_reg & s_reg.mclk_reg;
    ext_edge = s_reg.mclkin_s2_reg ^ s_reg.mclkin_prev_reg;
    s_next.bit_valid_reg = 2'b00;
    for (int c = 0; c < 2; c++) begin
      ch = (c == 0) ? cfg_a : cfg_b;
      // Drive bit clock only in clock-out mode
      s_next.mclk_oe_reg[c] = iaf_src_e'({1'b0, ch.source}) == IAF_SRC_EXT_CLKOUT;
      // External clock-in uses its own bit clock edges
      if (iaf_src_e'({1'b0, ch.source}) == IAF_SRC_EXT_CLKIN) begin
        tick[c] = ext_edge[c] && (s_reg.mclkin_s2_reg[c] == !ch.falling_edge);
      end else if (ch.full_clk) begin
        tick[c] = 1'b1;
      end else begin
        tick[c] = ch.falling_edge ? fall[c] : rise[c];
      end
      if (tick[c]) begin
        s_next.bit_reg[c] = s_reg.modulator_bitstream_s2_reg[c] ^ ch.invert;
        s_next.bit_valid_reg[c] = 1'b1;
      end
    end
    s_next.pready_reg = 1'b0;
    s_next.pslverr_reg = 1'b0;
    if (psel_i && !penable_i) begin
      s_next.pready_reg = 1'b1;
      s_next.prdata_reg = 32'h0000_0000;
    end
    if (rd_en) begin
      unique case (idx)
        IAF_IDX_INFO_DATA: s_next.prdata_reg = iaf_info(s_reg.info_word_selector_reg);
        IAF_IDX_INFO_SEL: s_next.prdata_reg = s_reg.info_word_selector_reg;
        IAF_IDX_RAW_DATA: s_next.prdata_reg = iaf_raw(s_reg.raw_sample_selector_reg, raw_i);
        IAF_IDX_RAW_SEL: s_next.prdata_reg = s_reg.raw_sample_selector_reg;
        IAF_IDX_MCFG: s_next.prdata_reg = s_reg.modulator_config_reg;
        IAF_IDX_MCLK_A: s_next.prdata_reg = s_reg.modulator_clock_increment_a_reg;
        IAF_IDX_MCLK_B: s_next.prdata_reg = s_reg.modulator_clock_increment_b_reg;
        default: s_next.prdata_reg = 32'h0000_0000;
      endcase
    end
    if (wr_en) begin
      unique case (idx)
        IAF_IDX_INFO_SEL: s_next.info_word_selector_reg =
          iaf_strb(s_reg.info_word_selector_reg, pwdata_i, pstrb_i);
        IAF_IDX_RAW_SEL: s_next.raw_sample_selector_reg =
          iaf_strb(s_reg.raw_sample_selector_reg, pwdata_i, pstrb_i);
        IAF_IDX_MCFG: s_next.modulator_config_reg =
          iaf_strb(s_reg.modulator_config_reg, pwdata_i, pstrb_i);
        IAF_IDX_MCLK_A: s_next.modulator_clock_increment_a_reg =
          iaf_strb(s_reg.modulator_clock_increment_a_reg, pwdata_i, pstrb_i);
        IAF_IDX_MCLK_B: s_next.modulator_clock_increment_b_reg =
          iaf_strb(s_reg.modulator_clock_increment_b_reg, pwdata_i, pstrb_i);
        default: s_next.info_word_selector_reg = s_reg.info_word_selector_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.info_word_selector_reg <= IAF_RST_INFO_SEL;
      s_reg.raw_sample_selector_reg <= IAF_RST_RAW_SEL;
      s_reg.modulator_config_reg <= IAF_RST_MCFG;
      s_reg.modulator_clock_increment_a_reg <= IAF_RST_MCLK_A;
      s_reg.modulator_clock_increment_b_reg <= IAF_RST_MCLK_B;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata_o = s_reg.prdata_reg;
  assign pready_o = s_reg.pready_reg;
  assign pslverr_o = s_reg.pslverr_reg;
  // Clock always on mclk_o, its enable set only in clock-out mode
  assign mclk_o = s_reg.mclk_reg;
  assign mclk_oe_o = s_reg.mclk_oe_reg;
  assign bit_o = s_reg.bit_reg;
  assign bit_valid_o = s_reg.bit_valid_reg;

  AST_RESET_MCLK_A: assert property (@(posedge clk_i)
    $fell(rst_i)
    |-> s_reg.modulator_clock_increment_a_reg == 32'h0CCC_CCCD)
    else $error("increment A reset wrong");

  AST_WR_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && idx == IAF_IDX_RAW_SEL && pstrb_i == 4'hF
    |=> s_reg.raw_sample_selector_reg == $past(pwdata_i))
    else $error("raw selector write lost");

  AST_WR_MCFG: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && idx == IAF_IDX_MCFG && pstrb_i == 4'hF
    |=> s_reg.modulator_config_reg == $past(pwdata_i))
    else $error("modulator config write lost");

  AST_RO_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && idx == IAF_IDX_INFO_DATA
    |=> $stable(s_reg.info_word_selector_reg))
    else $error("read-only write changed state");

  AST_UNUSED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en && idx > IAF_IDX_MCLK_B
    |=> prdata_o == 32'h0000_0000)
    else $error("unused not zero");

  AST_NO_ERR: assert property (@(posedge clk_i) disable iff (rst_i)
    pready_o
    |-> !pslverr_o)
    else $error("error response given");

  AST_INFO_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en && idx == IAF_IDX_INFO_DATA && s_reg.info_word_selector_reg[7:0] == 8'h03
    |=> prdata_o[31:24] == 8'h00)
    else $error("time above 24 bits");

  AST_INFO_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en && idx == IAF_IDX_INFO_DATA && s_reg.info_word_selector_reg[7:0] > 8'h05
    |=> prdata_o == 32'h0000_0000)
    else $error("unknown info selector not zero");

  AST_RAW_I: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en && idx == IAF_IDX_RAW_DATA && s_reg.raw_sample_selector_reg[1:0] == 2'h0
    |=> prdata_o == {$past(raw_i.phase_current1_sample), $past(raw_i.phase_current0_sample)})
    else $error("current pair wrong");

  AST_RAW_VM: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en && idx == IAF_IDX_RAW_DATA && s_reg.raw_sample_selector_reg[1:0] == 2'h1
    |=> prdata_o == {$past(raw_i.analog_input_a_sample), $past(raw_i.supply_voltage_sample)})
    else $error("supply pair wrong");

  AST_RAW_ENC: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_en && idx == IAF_IDX_RAW_DATA && s_reg.raw_sample_selector_reg[1:0] == 2'h3
    |=> prdata_o == {$past(raw_i.angle_sensor_wy_sample), $past(raw_i.angle_sensor_vn_sample)})
    else $error("encoder pair wrong");

  AST_READY: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && !penable_i
    |=> pready_o ##1 !pready_o)
    else $error("ready timing wrong");

  AST_EXT_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_a.source == 2'h1 && s_reg.mclkin_s2_reg[0] == s_reg.mclkin_prev_reg[0]
    |=> !bit_valid_o[0])
    else $error("external bit without clock edge");

  AST_MCLK_OE_B: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_b.source == 2'h2
    |=> mclk_oe_o[1])
    else $error("clock out not enabled");

  AST_MCLK_OE_A: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_a.source != 2'h2
    |=> !mclk_oe_o[0])
    else $error("clock out enabled outside clock-out mode");

  AST_DIV_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_a.source == 2'h0 && !cfg_a.full_clk && !cfg_a.falling_edge && !mclk_o[0]
    |=> bit_valid_o[0] == mclk_o[0])
    else $error("divided clock edge sample wrong");

  AST_INV: assert property (@(posedge clk_i) disable iff (rst_i)
    s_next.bit_valid_reg[0]
    |=> bit_o[0] == ($past(s_reg.modulator_bitstream_s2_reg[0]) ^ $past(cfg_a.invert)))
    else $error("inversion wrong");

  AST_FULLCLK: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_a.full_clk && cfg_a.source != 2'h1 && $stable(cfg_a)
    |=> bit_valid_o[0])
    else $error("full clock sample missing");

  AST_ACC_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i
    |=> s_reg.acc_a_reg == $past(s_reg.acc_a_reg) + $past(s_reg.modulator_clock_increment_a_reg) + 32'h0000_0001)
    else $error("phase step wrong");

  COV_RAW_READ: cover property (@(posedge clk_i) rd_en && idx == IAF_IDX_RAW_DATA);
  COV_INFO_READ: cover property (@(posedge clk_i) rd_en && idx == IAF_IDX_INFO_DATA);
  COV_CFG_WRITE: cover property (@(posedge clk_i) wr_en && idx == IAF_IDX_MCFG);
  COV_CLKOUT: cover property (@(posedge clk_i) cfg_b.source == 2'h2 && mclk_oe_o[1]);
  COV_EXT_BIT: cover property (@(posedge clk_i) cfg_a.source == 2'h1 && bit_valid_o[0]);
endmodule

// >>> src/iaf_pkg.sv
// Package: register map, field layout and types of the info and converter front-end bank
package iaf_pkg;
  localparam int unsigned IAF_ADDR_W = 7;
  localparam logic [IAF_ADDR_W-1:0] IAF_IDX_INFO_DATA = 7'h00;
  localparam logic [IAF_ADDR_W-1:0] IAF_IDX_INFO_SEL = 7'h01;
  localparam logic [IAF_ADDR_W-1:0] IAF_IDX_RAW_DATA = 7'h02;
  localparam logic [IAF_ADDR_W-1:0] IAF_IDX_RAW_SEL = 7'h03;
  localparam logic [IAF_ADDR_W-1:0] IAF_IDX_MCFG = 7'h04;
  localparam logic [IAF_ADDR_W-1:0] IAF_IDX_MCLK_A = 7'h05;
  localparam logic [IAF_ADDR_W-1:0] IAF_IDX_MCLK_B = 7'h06;
  localparam logic [31:0] IAF_RST_INFO_SEL = 32'h0000_0000;
  localparam logic [31:0] IAF_RST_RAW_SEL = 32'h0000_0000;
  localparam logic [31:0] IAF_RST_MCFG = 32'h0000_0000;
  localparam logic [31:0] IAF_RST_MCLK_A = 32'h0CCC_CCCD;
  localparam logic [31:0] IAF_RST_MCLK_B = 32'h0CCC_CCCD;
  localparam logic [31:0] IAF_SEL_MASK = 32'h0000_00FF;
  localparam logic [31:0] IAF_LO_MASK = 32'h0000_FFFF;
  localparam logic [31:0] IAF_HI_MASK = 32'hFFFF_0000;
  localparam int unsigned IAF_CH_B_POS = 16;
  localparam int unsigned IAF_SRC_POS = 0;
  localparam int unsigned IAF_EDGE_POS = 2;
  localparam int unsigned IAF_INV_POS = 3;
  localparam int unsigned IAF_FULLCLK_POS = 4;
  localparam int unsigned IAF_BLANK_POS = 8;
  // Arbitrary identity values
  localparam logic [31:0] IAF_HW_TYPE = 32'h4941_4631;
  localparam logic [31:0] IAF_HW_VERSION = 32'h0001_0000;
  localparam logic [31:0] IAF_HW_DATE = 32'h0000_0101;
  localparam logic [31:0] IAF_HW_TIME = 32'h0012_0000;
  localparam logic [31:0] IAF_HW_VARIANT = 32'h0000_0000;
  localparam logic [31:0] IAF_HW_BUILD = 32'h0000_0001;

  typedef enum logic [2:0] {
    IAF_SRC_INT = 3'b000,
    IAF_SRC_EXT_CLKIN = 3'b001,
    IAF_SRC_EXT_CLKOUT = 3'b010,
    IAF_SRC_EXT_CMP = 3'b011
  } iaf_src_e;

  typedef struct packed {
    logic [7:0] blanking;
    logic [2:0] spare;
    logic full_clk;
    logic invert;
    logic falling_edge;
    logic [1:0] source;
  } iaf_chcfg_s;

  typedef struct packed {
    logic [15:0] phase_current0_sample;
    logic [15:0] phase_current1_sample;
    logic [15:0] supply_voltage_sample;
    logic [15:0] analog_input_a_sample;
    logic [15:0] analog_input_b_sample;
    logic [15:0] angle_sensor_ux_sample;
    logic [15:0] angle_sensor_vn_sample;
    logic [15:0] angle_sensor_wy_sample;
  } iaf_raw_s;

  typedef struct packed {
    logic [31:0] info_word_selector_reg;
    logic [31:0] raw_sample_selector_reg;
    logic [31:0] modulator_config_reg;
    logic [31:0] modulator_clock_increment_a_reg;
    logic [31:0] modulator_clock_increment_b_reg;
    logic [31:0] acc_a_reg;
    logic [31:0] acc_b_reg;
    logic [1:0] mclk_reg;
    logic [1:0] mclk_oe_reg;
    logic [1:0] bit_reg;
    logic [1:0] bit_valid_reg;
    logic [1:0] modulator_bitstream_s1_reg;
    logic [1:0] modulator_bitstream_s2_reg;
    logic [1:0] mclkin_s1_reg;
    logic [1:0] mclkin_s2_reg;
    logic [1:0] mclkin_prev_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
  } iaf_state_s;
endpackage

// >>> tb/tb.sv
// Self-checking bench for the info and converter front-end register bank
`timescale 1ns/10ps
module tb
  import iaf_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0000_0000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  iaf_raw_s raw_i = '0;
  logic [1:0] modulator_bitstream_i = 2'b00;
  logic [1:0] mclk_ext_i = 2'b00;
  logic [1:0] mclk_o;
  logic [1:0] mclk_oe_o;
  logic [1:0] bit_o;
  logic [1:0] bit_valid_o;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] info_exp [0:6];
  int na;
  int nb;
  logic [1:0] prev;

  iaf_regs u_iaf_regs (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .raw_i(raw_i),
    .modulator_bitstream_i(modulator_bitstream_i), .mclk_ext_i(mclk_ext_i), .mclk_o(mclk_o), .mclk_oe_o(mclk_oe_o),
    .bit_o(bit_o), .bit_valid_o(bit_valid_o));

  always #20 clk_i = ~clk_i;

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Setup cycle, then access held until pready is seen high
  task automatic apb(input logic w, input logic [6:0] idx, input logic [31:0] wd, output logic [31:0] d);
    bit got;
    got = 0;
    d = 32'h0000_0000;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {23'h000000, idx, 2'b00};
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Read just after the edge, so the values are those the edge saw
    for (int k = 0; k < 20 && !got; k++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) begin
        got = 1;
        d = prdata_o;
        checks++;
        if (pslverr_o !== 1'b0) begin
          n_fail++;
          $display("MISMATCH at %0t: error response", $time);
        end
      end
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (!got) begin
      n_fail++;
      $display("MISMATCH at %0t: no pready", $time);
      summarize();
    end
  endtask

  task automatic wr(input logic [6:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    apb(1'b1, idx, wd, dummy);
  endtask

  task automatic rdchk(input logic [6:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] d;
    apb(1'b0, idx, 32'h0000_0000, d);
    chk(d, exp, what);
  endtask

  // Count changes of the modulator clocks over eight core cycles
  task automatic count_mclk();
    na = 0;
    nb = 0;
    @(negedge clk_i);
    prev = mclk_o;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_i);
      if (mclk_o[0] !== prev[0]) na++;
      if (mclk_o[1] !== prev[1]) nb++;
      prev = mclk_o;
    end
  endtask

  // Pulse the external bit clock of channel A and count sampled bits
  task automatic ext_bits(input logic [31:0] cfg, output int n);
    wr(IAF_IDX_MCFG, cfg);
    repeat (4) @(posedge clk_i);
    n = 0;
    for (int k = 0; k < 48; k++) begin
      @(posedge clk_i);
      mclk_ext_i[0] <= (k % 12) < 6 || k >= 42;
      if (bit_valid_o[0] === 1'b1) n++;
    end
    @(posedge clk_i);
    mclk_ext_i[0] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  initial begin
    info_exp = '{IAF_HW_TYPE, IAF_HW_VERSION, IAF_HW_DATE, IAF_HW_TIME, IAF_HW_VARIANT, IAF_HW_BUILD,
      32'h0000_0000};
    raw_i <= '{16'h1110, 16'h2221, 16'h3332, 16'h4443, 16'h5554, 16'h6665, 16'h7776, 16'h8887};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(IAF_IDX_INFO_SEL, IAF_RST_INFO_SEL, "info sel reset");
    rdchk(IAF_IDX_RAW_SEL, IAF_RST_RAW_SEL, "raw sel reset");
    rdchk(IAF_IDX_MCFG, IAF_RST_MCFG, "mcfg reset");
    rdchk(IAF_IDX_MCLK_A, 32'h0CCC_CCCD, "incr a reset");
    rdchk(IAF_IDX_MCLK_B, IAF_RST_MCLK_B, "incr b reset");
    chk(mclk_oe_o, 2'b00, "clock out enable reset");
    $display("test reset done");
    for (int s = 0; s < 7; s++) begin
      wr(IAF_IDX_INFO_SEL, s);
      rdchk(IAF_IDX_INFO_DATA, info_exp[s], "info word");
    end
    chk({8'h00, IAF_HW_TIME[23:0]}, IAF_HW_TIME, "time width");
    $display("test info done");
    wr(IAF_IDX_RAW_SEL, 32'h0000_0000);
    rdchk(IAF_IDX_RAW_DATA, 32'h2221_1110, "raw 0");
    wr(IAF_IDX_RAW_SEL, 32'h0000_0001);
    rdchk(IAF_IDX_RAW_DATA, 32'h4443_3332, "raw 1");
    wr(IAF_IDX_RAW_SEL, 32'h0000_0002);
    rdchk(IAF_IDX_RAW_DATA, 32'h6665_5554, "raw 2");
    wr(IAF_IDX_RAW_SEL, 32'h0000_0003);
    rdchk(IAF_IDX_RAW_DATA, 32'h8887_7776, "raw 3");
    $display("test raw done");
    wr(IAF_IDX_INFO_SEL, 32'h0000_0000);
    wr(IAF_IDX_INFO_DATA, 32'hDEAD_BEEF);
    rdchk(IAF_IDX_INFO_DATA, IAF_HW_TYPE, "ro info");
    wr(IAF_IDX_RAW_DATA, 32'hDEAD_BEEF);
    rdchk(IAF_IDX_RAW_DATA, 32'h8887_7776, "ro raw");
    wr(7'h07, 32'hFFFF_FFFF);
    rdchk(7'h07, 32'h0000_0000, "unused 7");
    wr(7'h7F, 32'hFFFF_FFFF);
    rdchk(7'h7F, 32'h0000_0000, "unused 127");
    $display("test decode done");
    wr(IAF_IDX_MCLK_A, 32'h8000_0000);
    wr(IAF_IDX_MCLK_B, 32'h4000_0000);
    rdchk(IAF_IDX_MCLK_A, 32'h8000_0000, "incr a");
    count_mclk();
    chk(na, 8, "mclk a toggles");
    chk(nb, 4, "mclk b toggles");
    $display("test mclk done");
    // Full core clock on both channels, B inverted
    wr(IAF_IDX_MCFG, 32'h0018_0010);
    rdchk(IAF_IDX_MCFG, 32'h0018_0010, "mcfg rw");
    modulator_bitstream_i <= 2'b11;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk(bit_o, 2'b01, "invert b");
    chk(bit_valid_o, 2'b11, "full clock valid");
    wr(IAF_IDX_MCFG, 32'h0010_0018);
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk(bit_o, 2'b10, "invert a");
    $display("test bitstream done");
    // Source 1 on A: four rising and three falling external clock edges
    @(posedge clk_i);
    modulator_bitstream_i <= 2'b01;
    ext_bits(32'h0000_0001, na);
    chk(na, 4, "ext rising bits");
    chk(bit_o[0], 1'b1, "ext bit value");
    ext_bits(32'h0000_0005, na);
    chk(na, 3, "ext falling bits");
    wr(IAF_IDX_MCFG, 32'h0002_0003);
    rdchk(IAF_IDX_MCFG, 32'h0002_0003, "source codes");
    chk(mclk_oe_o, 2'b10, "clock out enable");
    $display("test source done");
    summarize();
  end

  initial begin
    #3000000;
    n_fail++;
    $display("MISMATCH at %0t: run limit", $time);
    summarize();
  end
endmodule
